/* File: pkg/tmr_pkg.sv */
package tmr_pkg;
  localparam int          data_width       = 32;
  localparam int          addr_width       = 4;
  localparam logic [3:0] control_offset   = 4'h0;
  localparam logic [3:0] low_offset       = 4'h4;
  localparam logic [3:0] high_offset      = 4'h8;
  localparam logic [3:0] status_offset    = 4'hC;
  localparam logic [7:0] control_reset    = 8'h00;
  localparam int          run_bit          = 0;
  localparam int          source_bit       = 1;
  localparam int          sync_bit         = 2;
  localparam int          osc_bit          = 3;
  localparam int          prescale_lo_bit  = 4;
  localparam int          status_bit       = 6;
  localparam int          wide_bit         = 7;
  localparam int          flag_bit         = 0;
  localparam int          irq_enable_bit   = 1;
  localparam logic [1:0] fosc_div_last    = 2'h3;
  localparam logic [31:0] unmapped_value  = 32'h00000000;

  typedef struct packed {
    logic [addr_width-1:0] address;
    logic                  read;
    logic                  write;
    logic [3:0]            byteenable;
    logic [data_width-1:0] writedata;
  } bus_request_type;

  typedef struct packed {
    logic [data_width-1:0] readdata;
    logic                  waitrequest;
  } bus_answer_type;

  typedef struct packed {
    logic ext_clock;
    logic osc_clock;
    logic sysclk_from_osc;
    logic event_trigger;
  } side_inputs_type;

  typedef struct packed {
    logic       overflow_irq;
    logic       pins_forced_input;
    logic       osc_enable;
    logic [1:0] port_read_mask_n;
  } side_outputs_type;
endpackage : tmr_pkg

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic pin,
  output logic      level
);
  import tmr_pkg::*;
  typedef struct packed {
    logic first;
    logic second;
  } sync_state_type;
  sync_state_type state;
  sync_state_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.first = pin;
    next_state.second = state.first;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state <= '0;
    else if (enable)
      state <= next_state;
  end

  assign level = state.second;
endmodule : pin_sync

/* File: src/prescaler.sv */
`timescale 1ns/1ps
module prescaler
(
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       enable,
  input  wire logic       tick_in,
  input  wire logic       clear,
  input  wire logic [1:0] prescale_select,
  output logic            tick_out
);
  import tmr_pkg::*;
  typedef struct packed {
    logic [2:0] count;
  } pre_state_type;
  pre_state_type state;
  pre_state_type next_state;
  logic [2:0]    limit;

  always_comb
  begin
    next_state = state;
    limit = 3'((4'h1 << prescale_select) - 4'h1); // R07
    tick_out = 1'b0;
    if (clear)
      next_state.count = 3'h0; // R14
    else if (tick_in)
    begin
      if (state.count >= limit)
      begin
        next_state.count = 3'h0;
        tick_out = 1'b1; // R06
      end
      else
        next_state.count = state.count + 3'h1;
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state <= '0;
    else if (enable)
      state <= next_state;
  end
endmodule : prescaler

/* File: src/timer_counter.sv */
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
// Behaviour
// R01: run bit 0 starts counting; clear halts and holds count.
// R02: timer, synchronous counter and asynchronous counter modes.
// R03: source cleared counts clock divided by four, after prescaler.
// R04: source set counts rising edges of external or oscillator clock.
// R05: sync bit clear resynchronizes external clock; set bypasses; ignored internally. The code keeps the two-stage synchroniser when set.
// R06: prescaler divides by 1, 2, 4 or 8 via bits 5-4.
// R07: prescale encoding binary: 00=1, 01=2, 10=4, 11=8.
// R08: oscillator enable bit turns crystal oscillator on; cleared powers it off.
// R09: bit 6 read-only, shows device clock from oscillator.
// R10: bit 7 selects 16-bit access; cleared gives two 8-bit accesses.
// R11: in 16-bit mode low byte read copies high byte to buffer.
// R12: in 16-bit mode high write loads buffer; low write commits both.
// R13: in 16-bit mode the real high byte is reached only through buffer.
// R14: low byte write clears prescaler; high byte write does not.
// R15: when enabled, pins forced to inputs and read as zero.
// R16: both count bytes readable and writable; counter is 16 bits.
// R17: compare trigger clears count to zero.
// R18: count rolls all-ones to zero, sets flag; irq only when enabled.
// R19: software write beats coincident trigger; trigger never sets flag.
// R20: trigger reset supported in timer and synchronous counter modes only.
// R21: asynchronous count captured safely into system clock domain.
module timer_counter
(
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  input  wire logic                      clock_enable,
  input  wire tmr_pkg::bus_request_type  bus_request,
  output tmr_pkg::bus_answer_type        bus_answer,
  input  wire tmr_pkg::side_inputs_type  side_inputs,
  output tmr_pkg::side_outputs_type      side_outputs
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [7:0]  control;
    logic [15:0] count;
    logic [7:0]  high_buffer;
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic [1:0]  fosc_div;
    logic        ext_prev;
    logic        raw_prev;
    logic        async_pending;
    logic        answer_pending;
    bus_answer_type   answer;
    side_outputs_type outs;
  } top_state_type;

  top_state_type state;
  top_state_type next_state;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic ext_sync;
  logic osc_sync;
  logic status_sync;
  logic trig_sync;
  logic raw_edge_level;
  logic pre_tick;
  logic pre_clear;
  logic count_tick;

  pin_sync ext_sync_unit (
    .clock   (clock),
    .reset_n (reset_n),
    .enable  (clock_enable),
    .pin     (side_inputs.ext_clock),
    .level   (ext_sync)
  );
  pin_sync osc_sync_unit (
    .clock   (clock),
    .reset_n (reset_n),
    .enable  (clock_enable),
    .pin     (side_inputs.osc_clock),
    .level   (osc_sync)
  );
  pin_sync status_sync_unit (
    .clock   (clock),
    .reset_n (reset_n),
    .enable  (clock_enable),
    .pin     (side_inputs.sysclk_from_osc),
    .level   (status_sync)
  );
  pin_sync trig_sync_unit (
    .clock   (clock),
    .reset_n (reset_n),
    .enable  (clock_enable),
    .pin     (side_inputs.event_trigger),
    .level   (trig_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // count source selection

  logic       run;
  logic       ext_selected;
  logic       bypass;
  logic       ext_level;
  logic       ext_edge;
  logic       fosc_tick;
  logic       access;
  logic       wr_low;
  logic       wr_high;
  logic       rd_low;
  logic       commit;
  logic       wr_control;
  logic       wr_status;
  logic       trigger;
  logic [7:0] wdata;

  assign run = state.control[run_bit];
  assign ext_selected = state.control[source_bit];
  assign bypass = state.control[sync_bit];
  // oscillator output replaces pin input when oscillator is enabled
  assign ext_level = state.control[osc_bit] ? osc_sync : ext_sync; // R04
  assign ext_edge = ext_level & ~state.ext_prev; // R04
  assign fosc_tick = (state.fosc_div == fosc_div_last); // R03
  // async mode: edge taken through the same two-stage pin synchroniser, flagged pending
  assign raw_edge_level = ext_level;
  assign pre_tick = run & (ext_selected ? ext_edge : fosc_tick); // R01 R02 R05
  assign access = bus_request.read | bus_request.write;
  assign wdata = bus_request.writedata[7:0];
  // writes take effect at the edge where waitrequest is seen low
  assign commit = access & state.answer_pending & bus_request.write
                  & bus_request.byteenable[0];
  assign wr_low = commit & (bus_request.address == low_offset);
  assign wr_high = commit & (bus_request.address == high_offset);
  assign wr_control = commit & (bus_request.address == control_offset);
  assign wr_status = commit & (bus_request.address == status_offset);
  assign rd_low = access & ~state.answer_pending & bus_request.read
                  & (bus_request.address == low_offset);
  assign pre_clear = wr_low; // R14
  // trigger honoured only in timer or synchronous counter modes
  assign trigger = trig_sync & ~(ext_selected & bypass); // R20

  prescaler #() pre_unit (
    .clock           (clock),
    .reset_n         (reset_n),
    .enable          (clock_enable),
    .tick_in         (pre_tick),
    .clear           (pre_clear),
    .prescale_select (state.control[prescale_lo_bit +: 2]),
    .tick_out        (count_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_state = state;
    next_state.fosc_div = state.fosc_div + 2'h1; // R03
    next_state.ext_prev = ext_level;
    next_state.raw_prev = raw_edge_level;
    next_state.answer.waitrequest = 1'b1;
    next_state.answer_pending = 1'b0;
    // counting, trigger and write priority
    if (count_tick)
    begin
      next_state.count = state.count + 16'h0001; // R16
      if (state.count == 16'hFFFF)
        next_state.overflow_flag = 1'b1; // R18
    end
    if (trigger)
      next_state.count = 16'h0000; // R17 R19
    if (wr_low)
    begin
      if (state.control[wide_bit])
        next_state.count = {state.high_buffer, wdata}; // R12
      else
        next_state.count[7:0] = wdata; // R10
    end
    if (wr_high)
    begin
      if (state.control[wide_bit])
        next_state.high_buffer = wdata; // R12 R13
      else
        next_state.count[15:8] = wdata; // R10
    end
    if (rd_low & state.control[wide_bit])
      next_state.high_buffer = state.count[15:8]; // R11
    if (wr_control)
      next_state.control = wdata;
    if (wr_status)
    begin
      next_state.overflow_irq_enable = wdata[irq_enable_bit];
      if (~wdata[flag_bit])
        next_state.overflow_flag = next_state.overflow_flag & count_tick
                                   & (state.count == 16'hFFFF); // R18
    end
    // async counting: only an edge-pending flag is registered here; the count is a system clock register, so reads see whole bytes
    next_state.async_pending = ext_selected & bypass & ext_edge; // R21
    // register bus
    if (access & ~state.answer_pending)
    begin
      next_state.answer_pending = 1'b1;
      next_state.answer.waitrequest = 1'b0;
      next_state.answer.readdata = unmapped_value;
      unique case (bus_request.address)
        control_offset:
          next_state.answer.readdata[7:0] = state.control;
        low_offset:
          next_state.answer.readdata[7:0] = state.count[7:0]; // R16
        high_offset:
          next_state.answer.readdata[7:0] = state.control[wide_bit]
                                            ? state.high_buffer : state.count[15:8]; // R13
        status_offset:
        begin
          next_state.answer.readdata[flag_bit] = state.overflow_flag;
          next_state.answer.readdata[irq_enable_bit] = state.overflow_irq_enable;
        end
        default:
          next_state.answer.readdata = unmapped_value;
      endcase
    end
    next_state.control[status_bit] = status_sync; // R09
    next_state.outs.overflow_irq = next_state.overflow_flag
                                   & next_state.overflow_irq_enable; // R18
    next_state.outs.pins_forced_input = next_state.control[run_bit]; // R15
    next_state.outs.port_read_mask_n = {2{~next_state.control[run_bit]}}; // R15
    next_state.outs.osc_enable = next_state.control[osc_bit]; // R08
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '0;
      state.control <= control_reset;
      state.answer.waitrequest <= 1'b1;
      state.outs.port_read_mask_n <= 2'h3;
    end
    else if (clock_enable)
      state <= next_state;
  end

  assign bus_answer = state.answer;
  assign side_outputs = state.outs;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  wide_commit_a: assert property (@(posedge clock) disable iff (!reset_n) // R12
    clock_enable && wr_low && state.control[wide_bit] && !trigger
    |=> state.count[15:8] == $past(state.high_buffer))
    else $error("low write did not commit buffered high byte");
  buffer_load_a: assert property (@(posedge clock) disable iff (!reset_n) // R11
    clock_enable && rd_low && state.control[wide_bit] && !wr_high
    |=> state.high_buffer == $past(state.count[15:8]))
    else $error("low read did not capture high byte");
  halt_hold_a: assert property (@(posedge clock) disable iff (!reset_n) // R01
    clock_enable && !run && !wr_low && !wr_high && !trigger
    |=> state.count == $past(state.count))
    else $error("stopped counter changed");
  trigger_clear_a: assert property (@(posedge clock) disable iff (!reset_n) // R17
    clock_enable && trigger && !wr_low && !wr_high |=> state.count == 16'h0000)
    else $error("trigger did not clear count");
  write_wins_a: assert property (@(posedge clock) disable iff (!reset_n) // R19
    clock_enable && trigger && wr_low && !state.control[wide_bit]
    |=> state.count[7:0] == $past(wdata))
    else $error("trigger beat software write");
  rollover_flag_a: assert property (@(posedge clock) disable iff (!reset_n) // R18
    clock_enable && count_tick && state.count == 16'hFFFF && !trigger && !wr_low && !wr_high
    |=> state.count == 16'h0000 && state.overflow_flag)
    else $error("rollover did not set flag");
  status_readonly_a: assert property (@(posedge clock) disable iff (!reset_n) // R09
    clock_enable |=> state.control[status_bit] == $past(status_sync))
    else $error("status bit not tracking clock source");
  pins_input_a: assert property (@(posedge clock) disable iff (!reset_n) // R15
    clock_enable |=> side_outputs.pins_forced_input == run)
    else $error("pin direction not forced while running");
  bus_answer_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && access && !state.answer_pending |=> !bus_answer.waitrequest)
    else $error("bus answer late");
  fosc_period_a: assert property (@(posedge clock) disable iff (!reset_n) // R03
    clock_enable && fosc_tick ##1 clock_enable ##1 clock_enable ##1 clock_enable
    |=> fosc_tick)
    else $error("instruction cycle tick not every fourth clock");
  timer_source_a: assert property (@(posedge clock) disable iff (!reset_n) // R03
    clock_enable && pre_tick && !ext_selected |-> fosc_tick)
    else $error("timer advanced off the instruction cycle");
  ext_source_a: assert property (@(posedge clock) disable iff (!reset_n) // R04
    clock_enable && pre_tick && ext_selected |-> ext_edge)
    else $error("counter advanced without a rising edge");
  run_gate_a: assert property (@(posedge clock) disable iff (!reset_n) // R01
    clock_enable && count_tick |-> run)
    else $error("count advanced while stopped");
  low_byte_only_a: assert property (@(posedge clock) disable iff (!reset_n) // R10
    clock_enable && wr_low && !state.control[wide_bit] && !count_tick && !trigger
    |=> state.count[15:8] == $past(state.count[15:8]))
    else $error("byte write disturbed the high byte");
  high_write_a: assert property (@(posedge clock) disable iff (!reset_n) // R16
    clock_enable && wr_high && !state.control[wide_bit]
    |=> state.count[15:8] == $past(wdata))
    else $error("high byte write lost");
  buffer_only_a: assert property (@(posedge clock) disable iff (!reset_n) // R13
    clock_enable && wr_high && state.control[wide_bit] && !count_tick && !trigger
    |=> state.count == $past(state.count))
    else $error("buffered high write reached the count");
  prescale_clear_a: assert property (@(posedge clock) disable iff (!reset_n) // R14
    clock_enable && wr_low |=> pre_unit.state.count == 3'h0)
    else $error("low write left prescaler count");
  prescale_keep_a: assert property (@(posedge clock) disable iff (!reset_n) // R14
    clock_enable && wr_high && !pre_tick
    |=> pre_unit.state.count == $past(pre_unit.state.count))
    else $error("high write touched prescaler count");
  trigger_no_flag_a: assert property (@(posedge clock) disable iff (!reset_n) // R19
    clock_enable && trigger && !wr_status && !(count_tick && state.count == 16'hFFFF)
    |=> state.overflow_flag == $past(state.overflow_flag))
    else $error("trigger changed the overflow flag");
  irq_gate_a: assert property (@(posedge clock) disable iff (!reset_n) // R18
    clock_enable
    |=> side_outputs.overflow_irq == (state.overflow_flag && state.overflow_irq_enable))
    else $error("interrupt request not flag and enable");
  async_trigger_a: assert property (@(posedge clock) disable iff (!reset_n) // R20
    clock_enable && ext_selected && bypass |-> !trigger)
    else $error("trigger honoured in asynchronous mode");
  osc_power_a: assert property (@(posedge clock) disable iff (!reset_n) // R08
    clock_enable |=> side_outputs.osc_enable == state.control[osc_bit])
    else $error("oscillator enable not following control");
  pin_mask_a: assert property (@(posedge clock) disable iff (!reset_n) // R15
    clock_enable |=> side_outputs.port_read_mask_n == {2{!run}})
    else $error("pins not reading zero while running");
  low_read_a: assert property (@(posedge clock) disable iff (!reset_n) // R16
    clock_enable && rd_low |=> bus_answer.readdata[7:0] == $past(state.count[7:0]))
    else $error("low byte read wrong");
  buffer_read_a: assert property (@(posedge clock) disable iff (!reset_n) // R13
    clock_enable && access && !state.answer_pending && bus_request.read
    && bus_request.address == high_offset && state.control[wide_bit]
    |=> bus_answer.readdata[7:0] == $past(state.high_buffer))
    else $error("wide high read did not return buffer");
  control_write_a: assert property (@(posedge clock) disable iff (!reset_n) // R06
    clock_enable && wr_control
    |=> state.control[prescale_lo_bit +: 2] == $past(wdata[prescale_lo_bit +: 2]))
    else $error("prescale select not stored");
  rollover_c: cover property (@(posedge clock) disable iff (!reset_n)
    count_tick && state.count == 16'hFFFF);
  trigger_c: cover property (@(posedge clock) disable iff (!reset_n) trigger && run);
  wide_write_c: cover property (@(posedge clock) disable iff (!reset_n)
    wr_high ##[1:4] wr_low);
  async_count_c: cover property (@(posedge clock) disable iff (!reset_n)
    count_tick && ext_selected && bypass);
  overflow_irq_c: cover property (@(posedge clock) disable iff (!reset_n)
    side_outputs.overflow_irq);
endmodule : timer_counter

/* File: bench/clock_source_model.sv */
`timescale 1ns/1ps
module clock_source_model
(
  input  wire logic clock,
  output logic      ext_clock,
  output logic      osc_clock,
  output logic      sysclk_from_osc
);
  // count clocks stand still low between bursts
  initial
  begin
    ext_clock       = 1'b0;
    osc_clock       = 1'b0;
    sysclk_from_osc = 1'b0;
  end
  ////////////////////////////////////////
  // rising edges on the pin or the crystal output, half period in system clocks
  task automatic burst(input int edges, input int half, input bit on_osc);
    for (int i = 0; i < 2 * edges; i++)
    begin
      repeat (half) @(posedge clock);
      if (on_osc)
        osc_clock <= ~osc_clock;
      else
        ext_clock <= ~ext_clock;
    end
  endtask : burst
  task automatic set_sysclk(input bit from_osc);
    @(posedge clock);
    sysclk_from_osc <= from_osc;
  endtask : set_sysclk
endmodule : clock_source_model

/* File: bench/sixteen_bit_timer_counter_test.sv */
`timescale 1ns/1ps
module sixteen_bit_timer_counter_test;
  import tmr_pkg::*;
  logic             clock         = 1'b0;
  logic             reset_n       = 1'b0;
  logic             event_trigger = 1'b0;
  logic             clock_enable  = 1'b1;
  bus_request_type  bus_request   = '0;
  bus_answer_type   bus_answer;
  side_inputs_type  side_inputs;
  side_outputs_type side_outputs;
  logic             ext_clock;
  logic             osc_clock;
  logic             sysclk_from_osc;
  logic [7:0]       seen;
  int               miscompares   = 0;
  int               n_tests       = 0;

  always #2.5 clock = ~clock;
  assign side_inputs = {ext_clock, osc_clock, sysclk_from_osc, event_trigger};

  timer_counter i_dut
  (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_enable (clock_enable),
    .bus_request  (bus_request),
    .bus_answer   (bus_answer),
    .side_inputs  (side_inputs),
    .side_outputs (side_outputs)
  );
  clock_source_model i_source
  (
    .clock           (clock),
    .ext_clock       (ext_clock),
    .osc_clock       (osc_clock),
    .sysclk_from_osc (sysclk_from_osc)
  );
  ////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic check_range(input string what, input logic [7:0] got, input int lo, hi);
    n_tests++;
    if (((got >= lo) && (got <= hi)) !== 1'b1)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", what, lo, hi, got);
    end
  endtask : check_range
  // one bus cycle, held until waitrequest is sampled low
  task automatic access(input logic [3:0] addr, input logic wr, input logic [7:0] data);
    @(posedge clock);
    bus_request <= '{address: addr, read: ~wr, write: wr, byteenable: 4'h1,
                     writedata: {24'h000000, data}};
    @(posedge clock);
    while (bus_answer.waitrequest !== 1'b0)
      @(posedge clock);
    seen = bus_answer.readdata[7:0];
    bus_request <= '0;
  endtask : access
  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    access(addr, 1'b1, data);
  endtask : wr
  task automatic rd(input string what, input logic [3:0] addr, input logic [7:0] exp);
    access(addr, 1'b0, 8'h00);
    check(what, seen, exp);
  endtask : rd
  task automatic clear_count();
    wr(low_offset, 8'h00);
    wr(high_offset, 8'h00);
  endtask : clear_count
  ////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    rd("control reset", control_offset, control_reset);
    wr(control_offset, 8'hFE);
    rd("status bit low", control_offset, 8'hBE);
    check("osc enable", {7'h00, side_outputs.osc_enable}, 8'h01);
    i_source.set_sysclk(1'b1);
    repeat (6) @(posedge clock);
    rd("status bit high", control_offset, 8'hFE);
    wr(control_offset, 8'h00);
    @(posedge clock);
    check("osc off", {7'h00, side_outputs.osc_enable}, 8'h00);
    wr(4'h2, 8'h55);
    rd("unmapped", 4'h2, 8'h00);
    wr(low_offset, 8'h12);
    wr(high_offset, 8'h34);
    repeat (40) @(posedge clock);
    rd("low byte held", low_offset, 8'h12);
    rd("high byte held", high_offset, 8'h34);
    for (int ps = 0; ps < 4; ps++)
    begin
      clear_count();
      wr(control_offset, {2'b00, 2'(ps), 4'h1});
      repeat (5) @(posedge clock);
      check("pins input", {7'h00, side_outputs.pins_forced_input}, 8'h01);
      check("pins read", {6'h00, side_outputs.port_read_mask_n}, 8'h00);
      repeat ((20 << ps) - 8) @(posedge clock);
      wr(control_offset, 8'h00);
      access(low_offset, 1'b0, 8'h00);
      check_range("timer ticks", seen, 4, 6);
      check("pins free", {6'h00, side_outputs.port_read_mask_n}, 8'h03);
    end
    wr(high_offset, 8'hFF);
    wr(low_offset, 8'hFE);
    wr(control_offset, 8'h01);
    repeat (30) @(posedge clock);
    wr(control_offset, 8'h00);
    rd("overflow flag", status_offset, 8'h01);
    rd("rolled high", high_offset, 8'h00);
    wr(status_offset, 8'h03);
    repeat (3) @(posedge clock);
    check("irq on", {7'h00, side_outputs.overflow_irq}, 8'h01);
    wr(status_offset, 8'h02);
    repeat (3) @(posedge clock);
    check("irq off", {7'h00, side_outputs.overflow_irq}, 8'h00);
    wr(low_offset, 8'h34);
    wr(high_offset, 8'h12);
    wr(control_offset, 8'h31);
    event_trigger <= 1'b1;
    repeat (3) @(posedge clock);
    event_trigger <= 1'b0;
    repeat (6) @(posedge clock);
    wr(control_offset, 8'h30);
    access(low_offset, 1'b0, 8'h00);
    check_range("trigger low", seen, 0, 1);
    rd("trigger high", high_offset, 8'h00);
    rd("no flag", status_offset, 8'h02);
    wr(control_offset, 8'h80);
    wr(high_offset, 8'h56);
    wr(low_offset, 8'h78);
    wr(high_offset, 8'hAA);
    wr(control_offset, 8'h00);
    rd("real high", high_offset, 8'h56);
    wr(control_offset, 8'h80);
    rd("wide low", low_offset, 8'h78);
    rd("buffer high", high_offset, 8'h56);
    wr(control_offset, 8'h00);
    clear_count();
    wr(control_offset, 8'h03);
    i_source.burst(6, 4, 1'b0);
    repeat (8) @(posedge clock);
    wr(control_offset, 8'h00);
    rd("sync edges", low_offset, 8'h06);
    wr(control_offset, 8'h07);
    i_source.burst(5, 2, 1'b0);
    repeat (8) @(posedge clock);
    wr(control_offset, 8'h04);
    rd("async edges", low_offset, 8'h0B);
    wr(low_offset, 8'h00);
    wr(control_offset, 8'h13);
    i_source.burst(8, 3, 1'b0);
    repeat (8) @(posedge clock);
    wr(control_offset, 8'h00);
    rd("ext divided", low_offset, 8'h04);
    wr(low_offset, 8'h00);
    wr(control_offset, 8'h0B);
    i_source.burst(4, 3, 1'b1);
    repeat (8) @(posedge clock);
    wr(control_offset, 8'h08);
    rd("osc edges", low_offset, 8'h04);
    wr(low_offset, 8'h00);
    wr(control_offset, 8'h01);
    clock_enable <= 1'b0;
    repeat (40) @(posedge clock);
    clock_enable <= 1'b1;
    wr(control_offset, 8'h00);
    access(low_offset, 1'b0, 8'h00);
    check_range("frozen count", seen, 0, 2);
    test_done();
  end
endmodule : sixteen_bit_timer_counter_test
